// *** pkg/plc_tc_regs.svh ***
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: 32-bit AXI4-Lite data, byte addresses
// Notes: Definitions only
`ifndef PLC_TC_REGS_SVH
`define PLC_TC_REGS_SVH
`define CTRL_OFS 8'h00
`define STAT_OFS 8'h04
`define TSET_OFS 8'h08
`define CSET_OFS 8'h0c
`define CPV_OFS 8'h10
`define HSET_OFS 8'h14
`define HPV_OFS 8'h18
`define TPV_OFS 8'h1c
`define DATA_OFS 8'h20
`define FMT_OFS 8'h24
`define CTRL_RUN 0
`define CTRL_HEN 1
`define CTRL_HCLR 2
`define CTRL_HDIR 3
`define CTRL_CCLR 4
`define CTRL_LATCH 5
`define CTRL_CSRC 6
`define CTRL_TB_LO 8
`define CTRL_GRP_LO 12
`define STAT_TDONE 0
`define STAT_CDONE 1
`define STAT_HDONE 2
`define CTRL_RST 32'h0000_0001
`define CLK_HZ 25000000
`define TB_1MS_US 1000
`define TB_CYC_1MS ((`CLK_HZ / 1000000) * `TB_1MS_US)
`endif

// *** pkg/plc_tc_pkg.sv ***
// Purpose: Types shared by the timer and counter unit
// Assumes: Nothing beyond SystemVerilog
// Notes: Types only, constants live in the header
package plc_tc_pkg;
    typedef enum logic [1:0] {TB_1MS = 2'h0, TB_10MS = 2'h1, TB_100MS = 2'h2} time_base_t;
    typedef enum logic [1:0] {WR_IDLE = 2'h0, WR_RESP = 2'h1} wr_state_t;
    typedef struct packed {
        logic enable;
        logic clear;
        logic down;
    } hs_ctrl_t;
    typedef struct packed {
        logic [31:0] araddr;
        logic [31:0] awaddr;
    } axi_addr_t;
endpackage

// *** verilog/plc_timer_counter_unit.sv ***
// Purpose: Timer, 16-bit up counter and 32-bit up/down high-speed counter
// Assumes: Count pins asynchronous, scan strobe from same-clock logic
// Notes: Notes on behaviour below
`timescale 1ns/100ps
`include "plc_tc_regs.svh"
`default_nettype none
module plc_timer_counter_unit #(
    parameter int TB_CYCLES_1MS = `TB_CYC_1MS
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic power_good,
    input wire logic scan_end,
    input wire logic count_pin,
    input wire logic hs_pulse_pin,
    input wire logic [15:0] aux_bits,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic timer_contact,
    output logic count_contact,
    output logic hs_contact,
    output logic [15:0] aux_relays
);
    import plc_tc_pkg::*;

    // Pin synchronisers
    logic [1:0] cnt_sync_r, hs_sync_r, pg_sync_r;
    logic hs_prev_r;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_sync_r <= 2'h0;
            hs_sync_r <= 2'h0;
            pg_sync_r <= 2'h0;
            hs_prev_r <= 1'b0;
        end else if (clk_en) begin
            cnt_sync_r <= {cnt_sync_r[0], count_pin};
            hs_sync_r <= {hs_sync_r[0], hs_pulse_pin};
            pg_sync_r <= {pg_sync_r[0], power_good};
            hs_prev_r <= hs_sync_r[1];
        end
    end
    wire logic power_ok = pg_sync_r[1];
    // 25 MHz sampling gives 50 samples per 500 kHz period
    wire logic hs_edge = hs_sync_r[1] & ~hs_prev_r;

    // Registers
    logic [31:0] ctrl_r, tset_r, cset_r, hset_r, data_r, fmt_r;
    logic [15:0] tpv_r, cpv_r;
    logic [31:0] hpv_r;
    logic t_done_r, c_done_r, h_done_r, c_pend_r;
    logic cnt_scan_r, cnt_prev_r;

    wire logic run = ctrl_r[`CTRL_RUN];
    wire logic latch_cnt = ctrl_r[`CTRL_LATCH];
    wire logic reg_src = ctrl_r[`CTRL_CSRC];
    wire logic c_clr = ctrl_r[`CTRL_CCLR];
    wire time_base_t tbase = time_base_t'(ctrl_r[`CTRL_TB_LO +: 2]);
    wire logic [1:0] grp_cnt = ctrl_r[`CTRL_GRP_LO +: 2];
    hs_ctrl_t hs;
    assign hs.enable = ctrl_r[`CTRL_HEN];
    assign hs.clear = ctrl_r[`CTRL_HCLR];
    assign hs.down = ctrl_r[`CTRL_HDIR];

    // Time base tick
    logic [31:0] ms_cnt_r;
    logic [6:0] sub_cnt_r;
    wire logic ms_tick = (ms_cnt_r == 32'(TB_CYCLES_1MS - 1));
    wire logic [6:0] sub_lim = (tbase == TB_100MS) ? 7'h63 : (tbase == TB_10MS) ? 7'h09 : 7'h00;
    wire logic tb_tick = ms_tick & (sub_cnt_r == sub_lim);
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ms_cnt_r <= 32'h0;
            sub_cnt_r <= 7'h0;
        end else if (clk_en) begin
            ms_cnt_r <= ms_tick ? 32'h0 : ms_cnt_r + 32'h1;
            if (ms_tick)
                sub_cnt_r <= (sub_cnt_r == sub_lim) ? 7'h0 : sub_cnt_r + 7'h1;
        end
    end

    // Timer
    wire logic [15:0] tset = tset_r[15:0];
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tpv_r <= 16'h0;
        end else if (clk_en) begin
            if (!run)
                tpv_r <= 16'h0;
            else if (tb_tick && tpv_r != tset)
                tpv_r <= tpv_r + 16'h1;
        end
    end
    wire logic t_hit = run & (tpv_r == tset);

    // General counter setting, constant is positive only
    wire logic [15:0] cset_raw = cset_r[15:0];
    wire logic [15:0] cset_pos = {1'b0, cset_raw[14:0]};
    wire logic [15:0] cset_sel = reg_src ? cset_raw : cset_pos;
    wire logic [15:0] cset_eff = (cset_sel == 16'h0) ? 16'h1 : cset_sel;
    // Signed setting: only a same-sign value is above, a positive one must wrap to reach it
    wire logic cpv_above = (cpv_r > cset_eff) & (~reg_src | (cpv_r[15] == cset_eff[15]));
    wire logic c_reached = (cpv_r == cset_eff) | c_done_r;
    wire logic cnt_edge = scan_end & cnt_scan_r & ~cnt_prev_r;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_scan_r <= 1'b0;
            cnt_prev_r <= 1'b0;
        end else if (clk_en && scan_end) begin
            cnt_scan_r <= cnt_sync_r[1];
            cnt_prev_r <= cnt_scan_r;
        end
    end

    // Software writes
    wire logic aw_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    wire logic [7:0] waddr = s_axi_awaddr[7:0];
    wire logic [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                               {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction
    wire logic wr_ctrl = aw_go & (waddr == `CTRL_OFS);
    wire logic wr_cpv = aw_go & (waddr == `CPV_OFS);
    wire logic wr_hpv = aw_go & (waddr == `HPV_OFS);
    wire logic wr_data = aw_go & (waddr == `DATA_OFS);
    wire logic [31:0] wr_cpv_val = merge({16'h0, cpv_r}, s_axi_wdata, wmask);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= `CTRL_RST;
            tset_r <= 32'h0;
            cset_r <= 32'h0;
            hset_r <= 32'h0;
            fmt_r <= 32'h0;
        end else if (clk_en && aw_go) begin
            if (waddr == `CTRL_OFS)
                ctrl_r <= merge(ctrl_r, s_axi_wdata, wmask);
            if (waddr == `TSET_OFS)
                tset_r <= merge(tset_r, s_axi_wdata, wmask);
            if (waddr == `CSET_OFS)
                cset_r <= merge(cset_r, s_axi_wdata, wmask);
            if (waddr == `HSET_OFS)
                hset_r <= merge(hset_r, s_axi_wdata, wmask);
            if (waddr == `FMT_OFS)
                fmt_r <= merge(fmt_r, s_axi_wdata, wmask);
        end
    end

    // General counter: present value moves on the edge, contact at scan end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cpv_r <= 16'h0;
            c_pend_r <= 1'b0;
            c_done_r <= 1'b0;
        end else if (clk_en) begin
            if (!power_ok && !latch_cnt) begin
                cpv_r <= 16'h0;
                c_pend_r <= 1'b0;
                c_done_r <= 1'b0;
            end else if (!power_ok) begin
                cpv_r <= cpv_r;
            end else if (c_clr) begin
                cpv_r <= 16'h0;
                c_pend_r <= 1'b0;
                c_done_r <= 1'b0;
            end else begin
                if (wr_cpv)
                    cpv_r <= wr_cpv_val[15:0];
                else if (cnt_edge && cpv_above) begin
                    cpv_r <= cset_eff;
                    c_pend_r <= 1'b1;
                end else if (cnt_edge && !c_reached) begin
                    cpv_r <= cpv_r + 16'h1;
                    c_pend_r <= (cpv_r + 16'h1) == cset_eff;
                end
                if (scan_end && (c_pend_r || cpv_r == cset_eff))
                    c_done_r <= 1'b1;
            end
        end
    end

    // High-speed counter: contact reacts in the same cycle as the count
    wire logic [31:0] hpv_next = hs.down ? hpv_r - 32'h1 : hpv_r + 32'h1;
    wire logic hs_step = hs.enable & hs_edge & ~hs.clear;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            hpv_r <= 32'h0;
            h_done_r <= 1'b0;
        end else if (clk_en) begin
            if (!power_ok) begin
                hpv_r <= 32'h0;
                h_done_r <= 1'b0;
            end else if (hs.clear) begin
                hpv_r <= 32'h0;
                h_done_r <= 1'b0;
            end else if (wr_hpv) begin
                hpv_r <= merge(hpv_r, s_axi_wdata, wmask);
            end else if (hs_step) begin
                hpv_r <= hpv_next;
                if (hpv_next == hset_r)
                    h_done_r <= ~hs.down;
            end
        end
    end

    // General data register and relays
    logic run_prev_r;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            data_r <= 32'h0;
            run_prev_r <= 1'b0;
            aux_relays <= 16'h0;
        end else if (clk_en) begin
            run_prev_r <= run;
            if (!power_ok || (run_prev_r && !run))
                data_r <= 32'h0;
            else if (wr_data)
                data_r <= merge(data_r, s_axi_wdata, wmask);
            aux_relays <= power_ok ? aux_bits : 16'h0;
        end
    end

    // Timer contact registered at scan end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            t_done_r <= 1'b0;
        else if (clk_en && scan_end)
            t_done_r <= t_hit;
    end

    // BCD view of the data register and bit group view of the relay outputs
    logic [15:0] bcd_val;
    logic [15:0] grp_val;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_nib
            wire logic [3:0] nib = data_r[gi*4 +: 4];
            assign bcd_val[gi*4 +: 4] = (nib > 4'h9) ? 4'h9 : nib;
            assign grp_val[gi*4 +: 4] = (2'(gi) <= grp_cnt) ? aux_relays[gi*4 +: 4] : 4'h0;
        end
    endgenerate

    assign timer_contact = t_done_r;
    assign count_contact = c_done_r;
    assign hs_contact = h_done_r;

    // Write response
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            s_axi_bvalid <= 1'b0;
        else if (clk_en) begin
            if (aw_go)
                s_axi_bvalid <= 1'b1;
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end
    assign s_axi_awready = aw_go;
    assign s_axi_wready = aw_go;
    assign s_axi_bresp = 2'h0;

    // Read path
    wire logic [7:0] raddr = s_axi_araddr[7:0];
    wire logic ar_go = s_axi_arvalid & ~s_axi_rvalid;
    wire logic [31:0] stat_val = {29'h0, h_done_r, c_done_r, t_done_r};
    wire logic [31:0] rd_mux =
        (raddr == `CTRL_OFS) ? ctrl_r :
        (raddr == `STAT_OFS) ? stat_val :
        (raddr == `TSET_OFS) ? tset_r :
        (raddr == `CSET_OFS) ? cset_r :
        (raddr == `CPV_OFS) ? {16'h0, cpv_r} :
        (raddr == `HSET_OFS) ? hset_r :
        (raddr == `HPV_OFS) ? hpv_r :
        (raddr == `TPV_OFS) ? {16'h0, tpv_r} :
        (raddr == `DATA_OFS) ? data_r :
        (raddr == `FMT_OFS) ? {grp_val, fmt_r[0] ? bcd_val : data_r[15:0]} : 32'h0;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
        end else if (clk_en) begin
            if (ar_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
            end else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = ar_go;
    assign s_axi_rresp = 2'h0;

    // Checks
    chk_clear_zeroes: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && power_ok && c_clr |=> cpv_r == 16'h0 && !c_done_r)
        else $error("counter clear did not zero");
    chk_cnt_stops: assert property (@(posedge clk_sys) disable iff (!rstn)
        c_done_r && !c_clr && !wr_cpv && power_ok |=> $stable(cpv_r) || !rstn)
        else $error("counter moved after reaching setting");
    chk_cnt_latch: assert property (@(posedge clk_sys) disable iff (!rstn)
        c_done_r && power_ok && !c_clr && clk_en |=> c_done_r)
        else $error("counter contact dropped");
    chk_hs_idle: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && !hs.enable && !hs.clear && !wr_hpv && power_ok |=> $stable(hpv_r))
        else $error("hs counter moved while disabled");
    chk_hs_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && hs.clear |=> hpv_r == 32'h0)
        else $error("hs clear failed");
    chk_hs_up: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && hs_step && !hs.down && power_ok && !wr_hpv |=> hpv_r == $past(hpv_r) + 32'h1)
        else $error("hs up count wrong");
    chk_hs_contact: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && hs_step && power_ok && !wr_hpv && hpv_next == hset_r |=> h_done_r == !$past(hs.down))
        else $error("hs contact wrong at setting");
    chk_timer_eq: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && scan_end |=> timer_contact == $past(t_hit))
        else $error("timer contact mismatch");
    chk_data_stop: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && run_prev_r && !run |=> data_r == 32'h0)
        else $error("data not cleared on stop");
endmodule
`default_nettype wire

// *** tb/pulse_scan_model.sv ***
// Purpose: Far side of the unit: program scan strobe and pulse input terminals
// Assumes: Same clock as the unit, pins driven right after a rising edge
// Notes: Count input changes just after a scan end so the next scan sees one clean level
`timescale 1ns/100ps
`default_nettype none
module pulse_scan_model #(
    parameter int SCAN_CYC = 8
) (
    input wire logic clk_sys,
    input wire logic rstn,
    output logic scan_end,
    output logic count_pin,
    output logic hs_pulse_pin
);
    logic [7:0] scan_cnt_r;
    initial begin
        count_pin = 1'b0;
        hs_pulse_pin = 1'b0;
    end
    // Fixed short scan keeps the run brief; a real scan is far longer
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            scan_cnt_r <= 8'h00;
            scan_end <= 1'b0;
        end else begin
            scan_cnt_r <= (scan_cnt_r == 8'(SCAN_CYC - 1)) ? 8'h00 : scan_cnt_r + 8'h01;
            scan_end <= (scan_cnt_r == 8'(SCAN_CYC - 1));
        end
    end
    // One off-to-on-to-off cycle of the count input, each level held a whole scan
    task automatic count_edge();
        @(posedge clk_sys iff scan_end);
        count_pin <= 1'b1;
        @(posedge clk_sys iff scan_end);
        count_pin <= 1'b0;
        @(posedge clk_sys iff scan_end);
    endtask
    // Pulses of three cycles high, three low, well inside the input bandwidth
    task automatic hs_pulses(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            hs_pulse_pin <= 1'b1;
            repeat (3) @(posedge clk_sys);
            hs_pulse_pin <= 1'b0;
            repeat (2) @(posedge clk_sys);
        end
        repeat (6) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for the timer and counter unit over AXI4-Lite
// Assumes: Timer base shortened to 10 cycles per millisecond
// Notes: Handshakes are sampled on the rising edge at which they complete
`timescale 1ns/100ps
`include "plc_tc_regs.svh"
`default_nettype none
module testbench;
    import plc_tc_pkg::*;
    localparam int MS_CYC = 10;
    logic clk_sys, rstn, power_good;
    logic scan_end, count_pin, hs_pulse_pin;
    logic [15:0] aux_bits, aux_relays;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic timer_contact, count_contact, hs_contact;
    int mismatches = 0;
    int n_compared = 0;
    plc_timer_counter_unit #(.TB_CYCLES_1MS(MS_CYC)) i_plc_timer_counter_unit (
        .clk_sys(clk_sys), .rstn(rstn), .clk_en(1'b1), .power_good(power_good),
        .scan_end(scan_end), .count_pin(count_pin), .hs_pulse_pin(hs_pulse_pin),
        .aux_bits(aux_bits), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .timer_contact(timer_contact),
        .count_contact(count_contact), .hs_contact(hs_contact), .aux_relays(aux_relays)
    );
    pulse_scan_model i_pulse_scan_model (
        .clk_sys(clk_sys), .rstn(rstn), .scan_end(scan_end),
        .count_pin(count_pin), .hs_pulse_pin(hs_pulse_pin)
    );
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic axi_write(input logic [7:0] addr, input logic [31:0] data);
        @(posedge clk_sys);
        s_axi_awaddr <= {24'h000000, addr};
        s_axi_wdata <= data;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge clk_sys); while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1));
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [7:0] addr, output logic [31:0] data);
        @(posedge clk_sys);
        s_axi_araddr <= {24'h000000, addr};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
        data = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask
    task automatic scans(input int n);
        repeat (n * 8 + 4) @(posedge clk_sys);
    endtask
    task automatic cclear(input logic [31:0] ctl);
        axi_write(`CTRL_OFS, ctl | 32'h0000_0010);
        axi_write(`CTRL_OFS, ctl);
    endtask
    task automatic power_blip();
        @(posedge clk_sys);
        power_good <= 1'b0;
        repeat (10) @(posedge clk_sys);
        check({16'h0000, aux_relays}, 32'h0000_0000);
        power_good <= 1'b1;
        repeat (10) @(posedge clk_sys);
    endtask
    task automatic report_and_stop();
        $display("Compared %0d values, %0d mismatches", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #(40 * 60000);
        mismatches++;
        report_and_stop();
    end
    initial begin
        rstn = 1'b0;
        power_good = 1'b1;
        aux_bits = 16'ha5a5;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        axi_read(`CTRL_OFS, rd);
        check(rd, `CTRL_RST);
        axi_read(8'h40, rd);
        check(rd, 32'h0000_0000);
        // General counter: stops and latches at the setting
        axi_write(`CSET_OFS, 32'h0000_0003);
        repeat (5) i_pulse_scan_model.count_edge();
        scans(2);
        axi_read(`CPV_OFS, rd);
        check(rd, 32'h0000_0003);
        check({31'h0, count_contact}, 32'h1);
        // Clear together with a count edge
        axi_write(`CTRL_OFS, 32'h0000_0011);
        i_pulse_scan_model.count_edge();
        axi_read(`CPV_OFS, rd);
        check(rd, 32'h0000_0000);
        scans(2);
        check({31'h0, count_contact}, 32'h0);
        axi_write(`CTRL_OFS, 32'h0000_0001);
        axi_write(`CSET_OFS, 32'h0000_0000);
        i_pulse_scan_model.count_edge();
        scans(2);
        check({31'h0, count_contact}, 32'h1);
        cclear(32'h0000_0001);
        axi_write(`CSET_OFS, 32'h0000_0003);
        axi_write(`CPV_OFS, 32'h0000_000a);
        i_pulse_scan_model.count_edge();
        scans(2);
        axi_read(`CPV_OFS, rd);
        check(rd, 32'h0000_0003);
        check({31'h0, count_contact}, 32'h1);
        // Signed register setting lets the count wrap
        // Setting of -1 lies past the wrap, so a clamp to the setting would read 0xffff
        cclear(32'h0000_0041);
        axi_write(`CSET_OFS, 32'h0000_ffff);
        axi_write(`CPV_OFS, 32'h0000_7fff);
        i_pulse_scan_model.count_edge();
        axi_read(`CPV_OFS, rd);
        check(rd & 32'h0000_ffff, 32'h0000_8000);
        // Constant setting drops the sign bit: 0x8001 acts as 1
        cclear(32'h0000_0001);
        axi_write(`CSET_OFS, 32'h0000_8001);
        i_pulse_scan_model.count_edge();
        scans(2);
        check({31'h0, count_contact}, 32'h1);
        // Power loss clears unlatched counter and data, holds latched counter
        axi_write(`DATA_OFS, 32'h0000_1234);
        power_blip();
        axi_read(`CPV_OFS, rd);
        check(rd, 32'h0000_0000);
        axi_read(`DATA_OFS, rd);
        check(rd, 32'h0000_0000);
        axi_write(`CTRL_OFS, 32'h0000_0021);
        axi_write(`CPV_OFS, 32'h0000_0002);
        power_blip();
        axi_read(`CPV_OFS, rd);
        check(rd, 32'h0000_0002);
        axi_write(`DATA_OFS, 32'h0000_5678);
        axi_write(`CTRL_OFS, 32'h0000_0000);
        axi_read(`DATA_OFS, rd);
        check(rd, 32'h0000_0000);
        // BCD view and bit groups of one to four nibbles
        axi_write(`FMT_OFS, 32'h0000_0001);
        for (int g = 0; g < 4; g++) begin
            axi_write(`CTRL_OFS, 32'(g) << `CTRL_GRP_LO);
            axi_write(`DATA_OFS, 32'h0000_12a4);
            axi_read(`FMT_OFS, rd);
            check(rd, {16'ha5a5 & 16'((32'h1 << (4 * (g + 1))) - 1), 16'h1294});
        end
        // High-speed counter passes its setting, then counts down back onto it
        axi_write(`CTRL_OFS, 32'h0000_0003);
        axi_write(`HSET_OFS, 32'h0000_0003);
        i_pulse_scan_model.hs_pulses(4);
        axi_read(`HPV_OFS, rd);
        check(rd, 32'h0000_0004);
        check({31'h0, hs_contact}, 32'h1);
        axi_read(`STAT_OFS, rd);
        check(rd, 32'h0000_0005);
        axi_write(`CTRL_OFS, 32'h0000_000b);
        i_pulse_scan_model.hs_pulses(1);
        check({31'h0, hs_contact}, 32'h0);
        axi_write(`CTRL_OFS, 32'h0000_0009);
        i_pulse_scan_model.hs_pulses(2);
        axi_read(`HPV_OFS, rd);
        check(rd, 32'h0000_0003);
        axi_write(`CTRL_OFS, 32'h0000_000f);
        axi_write(`CTRL_OFS, 32'h0000_000b);
        axi_write(`HSET_OFS, 32'hffff_fffe);
        i_pulse_scan_model.hs_pulses(2);
        axi_read(`HPV_OFS, rd);
        check(rd, 32'hffff_fffe);
        // Timer delay is base times setting for every base
        for (int b = 0; b < 3; b++) begin
            axi_write(`TSET_OFS, 32'h0000_0004);
            axi_write(`CTRL_OFS, 32'h0000_0000);
            axi_write(`CTRL_OFS, 32'h0000_0001 | (32'(b) << `CTRL_TB_LO));
            repeat (2 * MS_CYC * (10 ** b)) @(posedge clk_sys);
            check({31'h0, timer_contact}, 32'h0);
            repeat (2 * MS_CYC * (10 ** b) + 30) @(posedge clk_sys);
            check({31'h0, timer_contact}, 32'h1);
            axi_read(`TPV_OFS, rd);
            check(rd, 32'h0000_0004);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
